// >>> hdl/cms_chopper_mode_switch.sv
/*
  Chopper mode selection, regulation hold, open-load flags, amplitude
  readout and standstill options for a two-coil stepper driver.
  Assumes all inputs synchronous to clk_in; the regulator loop and the
  PWM stage live outside and exchange plain levels and strobes here.
*/
// How it works
// [R1] Voltage mode below the velocity threshold, current mode above it.
// [R2] Step interval below 20-bit threshold disables voltage mode.
// [R3] Threshold may load from one-time memory at startup.
// [R4] Threshold zero keeps voltage mode at every velocity.
// [R5] Host reads step interval at transition velocity, writes threshold.
// [R6] Regulation setting is held in current mode and resumed later.
// [R7] Host keeps threshold and supply steady during current mode.
// [R8] First voltage-mode enable needs 128 chopper periods at standstill.
// [R9] After unrecoverable state host clears flags, restarts from zero.
// [R10] Voltage-mode current flags may update later than current mode.
// [R11] Open-load flag set if target not reached in last fullsteps.
// [R12] Interrupted coil gives a steady, not flickering, open-load flag.
// [R13] Host does on-demand open-load test in current mode.
// [R14] Amplitude total shows voltage needed for target current.
// [R15] Amplitude total saturates at 255, meaning current not sustained.
// [R16] Standstill option applies after powerdown and hold ramp delays.
// [R17] Regulation state freezes while target current is zero.
// [R18] Option: 0 normal, 1 standstill_option, 2 low short, 3 high short.
// [R19] Chopper select is config disable bit XOR select pin.
// [R20] Voltage mode needs both select bit and threshold to allow it.
`timescale 1ns/100ps
`default_nettype none
module cms_chopper_mode_switch
  import cms_pkg::*;
#(
  parameter int OPEN_STEPS = OPEN_FULLSTEPS
) (
  // Clock and reset
  input  wire  logic              clk_in,
  input  wire  logic              reset_in,
  // Configuration
  input  wire  logic              otp_load_in,
  input  wire  logic [THRS_W-1:0] otp_threshold_in,
  input  wire  logic              threshold_write_in,
  input  wire  logic [THRS_W-1:0] threshold_data_in,
  input  wire  logic              voltage_mode_disable_in,
  input  wire  logic              chopper_select_pin_in,
  input  wire  logic              autoscale_in,
  input  wire  logic [4:0]        standstill_current_in,
  input  wire  logic [1:0]        standstill_option_in,
  // Motion and regulator status
  input  wire  logic [THRS_W-1:0] step_interval_measure_in,
  input  wire  logic              standstill_in,
  input  wire  logic              chopper_period_in,
  input  wire  logic              fullstep_in,
  input  wire  logic              powerdown_done_in,
  input  wire  logic              hold_ramp_done_in,
  input  wire  logic              target_zero_in,
  input  wire  logic              reg_update_in,
  input  wire  logic [AMP_W-1:0]  reg_value_in,
  input  wire  logic              coil_a_reached_in,
  input  wire  logic              coil_b_reached_in,
  input  wire  logic [AMP_W:0]    amp_demand_in,
  // Mode and status outputs
  output logic                    voltage_mode_out,
  output logic                    init_done_out,
  output logic [THRS_W-1:0]       velocity_mode_threshold_out,
  output logic [AMP_W-1:0]        reg_hold_out,
  output logic                    open_load_coil_a_out,
  output logic                    open_load_coil_b_out,
  output logic [AMP_W-1:0]        pwm_amplitude_total_out,
  output logic                    amp_saturated_out,
  // Bridge control
  output logic                    bridge_enable_out,
  output logic                    short_low_out,
  output logic                    short_high_out
);

  // ==========================================================
  // Mode decision
  // ==========================================================
  logic [THRS_W-1:0] threshold;
  logic [THRS_W-1:0] next_threshold;
  logic              sel_allows_voltage;
  logic              thr_forces_current;
  logic              want_voltage;

  // Config bit inverted by the pin; high means voltage mode disabled
  assign sel_allows_voltage =
      ~(voltage_mode_disable_in ^ chopper_select_pin_in); // see [R19]
  // Zero threshold never forces current mode
  assign thr_forces_current = (threshold != THRS_RESET) &&
      (step_interval_measure_in < threshold); // see [R2] see [R4]
  assign want_voltage = sel_allows_voltage &
      ~thr_forces_current; // see [R1] see [R20]

  always_comb begin
    next_threshold = threshold;
    if (threshold_write_in) begin
      next_threshold = threshold_data_in;
    end else if (otp_load_in) begin
      next_threshold = otp_threshold_in; // see [R3]
    end
  end

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      threshold <= THRS_RESET;
    end else begin
      threshold <= next_threshold;
    end
  end

  // ==========================================================
  // Mode state machine with standstill initialisation
  // ==========================================================
  cms_state_e state;
  cms_state_e next_state;
  logic [7:0] init_cnt;
  logic [7:0] next_init_cnt;
  logic       init_done;
  logic       next_init_done;

  always_comb begin
    next_state     = state;
    next_init_cnt  = init_cnt;
    next_init_done = init_done;
    case (state)
      CMS_INIT: begin
        if (!want_voltage) begin
          next_state    = CMS_CURRENT;
          next_init_cnt = 8'h00;
        end else if (!standstill_in) begin
          // Motion restarts the standstill wait
          next_init_cnt = 8'h00;
        end else if (chopper_period_in) begin
          if (init_cnt == STANDSTILL_CNT - 8'h01) begin
            next_state     = CMS_VOLTAGE; // see [R8]
            next_init_done = 1'b1;
          end else begin
            next_init_cnt = init_cnt + 8'h01;
          end
        end
      end
      CMS_VOLTAGE: begin
        if (!want_voltage) begin
          next_state = CMS_CURRENT;
        end
      end
      CMS_CURRENT: begin
        if (want_voltage) begin
          next_state = init_done ? CMS_VOLTAGE : CMS_INIT; // see [R6]
        end
      end
      default: begin
        next_state = CMS_INIT;
      end
    endcase
  end

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      state     <= CMS_INIT;
      init_cnt  <= 8'h00;
      init_done <= 1'b0;
    end else begin
      state     <= next_state;
      init_cnt  <= next_init_cnt;
      init_done <= next_init_done;
    end
  end

  logic in_voltage;
  assign in_voltage = (state == CMS_VOLTAGE);

  // ==========================================================
  // Held regulation setting
  // ==========================================================
  logic [AMP_W-1:0] reg_hold;
  logic [AMP_W-1:0] next_reg_hold;

  // Updates only in voltage mode with nonzero target current
  always_comb begin
    next_reg_hold = reg_hold;
    if (reg_update_in && in_voltage && !target_zero_in) begin
      next_reg_hold = reg_value_in; // see [R6] see [R17]
    end
  end

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      reg_hold <= AMP_RESET;
    end else begin
      reg_hold <= next_reg_hold;
    end
  end

  // ==========================================================
  // Open-load flags per coil
  // ==========================================================
  logic [1:0] reached;
  logic [1:0] open_flag;
  logic [1:0] next_open_flag;
  logic [2:0] miss_cnt      [2];
  logic [2:0] next_miss_cnt [2];

  assign reached = {coil_b_reached_in, coil_a_reached_in};

  // Flags judge on fullstep boundaries, so they lag by design
  generate
    for (genvar c = 0; c < 2; c++) begin : g_coil
      always_comb begin
        next_miss_cnt[c]  = miss_cnt[c];
        next_open_flag[c] = open_flag[c];
        if (!in_voltage) begin
          next_miss_cnt[c]  = 3'h0;
          next_open_flag[c] = 1'b0;
        end else if (fullstep_in) begin // see [R10]
          if (reached[c]) begin
            next_miss_cnt[c]  = 3'h0;
            next_open_flag[c] = 1'b0;
          end else if (miss_cnt[c] >= 3'(OPEN_STEPS - 1)) begin
            // Saturating count keeps a dead coil's flag steady
            next_miss_cnt[c]  = 3'(OPEN_STEPS); // see [R12]
            next_open_flag[c] = 1'b1; // see [R11]
          end else begin
            next_miss_cnt[c] = miss_cnt[c] + 3'h1;
          end
        end
      end

      always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
          miss_cnt[c]  <= 3'h0;
          open_flag[c] <= 1'b0;
        end else begin
          miss_cnt[c]  <= next_miss_cnt[c];
          open_flag[c] <= next_open_flag[c];
        end
      end
    end
  endgenerate

  // ==========================================================
  // Amplitude total readout
  // ==========================================================
  logic [AMP_W-1:0] amp_total;
  logic [AMP_W-1:0] next_amp_total;

  always_comb begin
    next_amp_total = amp_total;
    if (autoscale_in) begin
      if (amp_demand_in[AMP_W]) begin
        next_amp_total = AMP_LIMIT; // see [R15]
      end else begin
        next_amp_total = amp_demand_in[AMP_W-1:0]; // see [R14]
      end
    end
  end

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      amp_total <= AMP_RESET;
    end else begin
      amp_total <= next_amp_total;
    end
  end

  // ==========================================================
  // Standstill options
  // ==========================================================
  logic [2:0] bridge;
  logic [2:0] next_bridge;
  logic       option_active;

  // Only meaningful in voltage mode; current mode keeps driving
  assign option_active = in_voltage &&
      (standstill_current_in == 5'h00) &&
      powerdown_done_in && hold_ramp_done_in; // see [R16]

  // Bits: enable, low short, high short
  always_comb begin
    next_bridge = 3'b100;
    if (option_active) begin
      case (standstill_option_in) // see [R18]
        OPT_NORMAL:    next_bridge = 3'b100;
        OPT_STANDSTILL_OPTION: next_bridge = 3'b000;
        OPT_SHORT_LS:  next_bridge = 3'b010;
        OPT_SHORT_HS:  next_bridge = 3'b001;
        default:       next_bridge = 3'b100;
      endcase
    end
  end

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      bridge <= 3'b000;
    end else begin
      bridge <= next_bridge;
    end
  end

  // ==========================================================
  // Outputs
  // ==========================================================
  assign voltage_mode_out            = in_voltage;
  assign init_done_out               = init_done;
  assign velocity_mode_threshold_out = threshold;
  assign reg_hold_out                = reg_hold;
  assign open_load_coil_a_out        = open_flag[0];
  assign open_load_coil_b_out        = open_flag[1];
  assign pwm_amplitude_total_out     = amp_total;
  assign amp_saturated_out           = (amp_total == AMP_LIMIT);
  assign bridge_enable_out           = bridge[2];
  assign short_low_out               = bridge[1];
  assign short_high_out              = bridge[0];

endmodule
`default_nettype wire

// >>> hdl/cms_pkg.sv
/*
  Constants for the chopper mode switch control block.
  Assumes a single 200 MHz driver clock domain.
*/
package cms_pkg;
  localparam int          THRS_W          = 20;
  localparam logic [19:0] THRS_RESET      = 20'h00000;
  localparam logic [19:0] THRS_MAX        = 20'hFFFFF;
  localparam int          AMP_W           = 8;
  localparam logic [7:0]  AMP_LIMIT       = 8'hFF;
  localparam logic [7:0]  AMP_RESET       = 8'h00;
  localparam int          STANDSTILL_PERIODS = 128;
  localparam logic [7:0]  STANDSTILL_CNT  = 8'h80;
  localparam int          OPEN_FULLSTEPS  = 4;
  localparam logic [2:0]  OPEN_CNT_MAX    = 3'h4;
  localparam logic [1:0]  OPT_NORMAL      = 2'h0;
  localparam logic [1:0]  OPT_STANDSTILL_OPTION   = 2'h1;
  localparam logic [1:0]  OPT_SHORT_LS    = 2'h2;
  localparam logic [1:0]  OPT_SHORT_HS    = 2'h3;
  typedef enum logic [1:0] {
    CMS_INIT, CMS_VOLTAGE, CMS_CURRENT
  } cms_state_e;
endpackage

// >>> testbench/cms_chk.sv
/*
  Port checker for the chopper mode switch block.
  Assumes it is bound to cms_chopper_mode_switch, one clock domain.
*/
`timescale 1ns/100ps
`default_nettype none
// ==================
// Checker
module cms_chk
  import cms_pkg::*;
(
  // Clock, reset and configuration
  input wire logic        clk_in, reset_in, otp_load_in,
  input wire logic        threshold_write_in, voltage_mode_disable_in,
  input wire logic        chopper_select_pin_in, autoscale_in,
  input wire logic [19:0] otp_threshold_in, step_interval_measure_in,
  input wire logic [4:0]  standstill_current_in,
  input wire logic [1:0]  standstill_option_in,
  // Motion and regulator status
  input wire logic        powerdown_done_in, hold_ramp_done_in,
  input wire logic        target_zero_in, fullstep_in, coil_a_reached_in,
  input wire logic [8:0]  amp_demand_in,
  // Outputs watched
  input wire logic        voltage_mode_out, open_load_coil_a_out,
  input wire logic        bridge_enable_out, short_low_out, short_high_out,
  input wire logic [19:0] velocity_mode_threshold_out,
  input wire logic [7:0]  reg_hold_out, pwm_amplitude_total_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (reset_in);
  logic [2:0] brg;
  logic [2:0] want_brg;
  logic       sel_cur;
  assign brg      = {bridge_enable_out, short_low_out, short_high_out};
  assign sel_cur  = voltage_mode_disable_in ^ chopper_select_pin_in;
  assign want_brg = (standstill_option_in == OPT_STANDSTILL_OPTION) ? 3'h0 :
                    (standstill_option_in == OPT_SHORT_LS) ? 3'h2 :
                    (standstill_option_in == OPT_SHORT_HS) ? 3'h1 : 3'h4;
  sequence too_fast;
    voltage_mode_out && velocity_mode_threshold_out != 20'h00000
      && step_interval_measure_in < velocity_mode_threshold_out;
  endsequence
  sequence brake_ready;
    voltage_mode_out && standstill_current_in == 5'h00
      && powerdown_done_in && hold_ramp_done_in;
  endsequence
  otp_load_a: assert property (otp_load_in && !threshold_write_in
    |=> velocity_mode_threshold_out == $past(otp_threshold_in))
    else $error("otp threshold not loaded");
  fast_cur_a: assert property (too_fast |=> !voltage_mode_out)
    else $error("voltage mode kept above threshold velocity");
  zero_thr_a: assert property (voltage_mode_out && !sel_cur
    && velocity_mode_threshold_out == 20'h00000 && !threshold_write_in
    && !otp_load_in |=> voltage_mode_out)
    else $error("zero threshold left voltage mode");
  sel_cur_a: assert property (sel_cur |=> !voltage_mode_out)
    else $error("select bit ignored");
  hold_reg_a: assert property (!voltage_mode_out || target_zero_in
    |=> $stable(reg_hold_out))
    else $error("held regulation changed");
  amp_track_a: assert property (autoscale_in |=>
    pwm_amplitude_total_out == ($past(amp_demand_in[8]) ? 8'hFF :
    $past(amp_demand_in[7:0])))
    else $error("amplitude total wrong");
  open_rise_a: assert property ($rose(open_load_coil_a_out) |->
    $past(fullstep_in && !coil_a_reached_in))
    else $error("open load flag set without a missed fullstep");
  brake_opt_a: assert property (brake_ready |=>
    brg == $past(want_brg))
    else $error("standstill option decode wrong");
endmodule
bind cms_chopper_mode_switch cms_chk chk_i (.*);
`default_nettype wire

// >>> testbench/cms_coil_model.sv
/*
  Two-coil motor model: a coil reaches target current while the bridge
  drives it, unless the bench has broken that coil.
*/
`timescale 1ns/100ps
`default_nettype none
// ==================
// Coil model
module cms_coil_model (
  input  wire logic bridge_on_in,
  input  wire logic open_a_in,
  input  wire logic open_b_in,
  output logic      reached_a_out,
  output logic      reached_b_out
);
  // A broken coil never reaches target, so its flag stays up in voltage mode
  assign reached_a_out = bridge_on_in & ~open_a_in;
  assign reached_b_out = bridge_on_in & ~open_b_in;
endmodule
`default_nettype wire

// >>> testbench/tb_top.sv
/*
  Self-checking bench for the chopper mode switch block.
  Assumes the coil model and the bound checker.
*/
`timescale 1ns/100ps
`default_nettype none
// ==================
// Bench
module tb_top;
  import cms_pkg::*;
  logic        clk_in, reset_in, otp_load_in, threshold_write_in;
  logic        voltage_mode_disable_in, chopper_select_pin_in;
  logic        autoscale_in, standstill_in, chopper_period_in;
  logic        fullstep_in, powerdown_done_in, hold_ramp_done_in;
  logic        target_zero_in, reg_update_in, coil_a_reached_in;
  logic        coil_b_reached_in, open_a, open_b, voltage_mode_out;
  logic        init_done_out, open_load_coil_a_out, open_load_coil_b_out;
  logic        amp_saturated_out, bridge_enable_out;
  logic        short_low_out, short_high_out;
  logic [19:0] otp_threshold_in, threshold_data_in;
  logic [19:0] step_interval_measure_in, velocity_mode_threshold_out;
  logic [8:0]  amp_demand_in;
  logic [7:0]  reg_value_in, reg_hold_out, pwm_amplitude_total_out;
  logic [4:0]  standstill_current_in;
  logic [1:0]  standstill_option_in;
  int          errors, comparisons, cycles;
  logic [2:0]  bridge_bits;
  assign bridge_bits = {bridge_enable_out, short_low_out, short_high_out};
  cms_chopper_mode_switch dut (.*);
  cms_coil_model coils (.bridge_on_in(bridge_enable_out),
    .open_a_in(open_a), .open_b_in(open_b),
    .reached_a_out(coil_a_reached_in), .reached_b_out(coil_b_reached_in));
  task ed; @(posedge clk_in); endtask
  task sn; @(negedge clk_in); endtask
  task wt; ed; sn; endtask
  task chp; ed; chopper_period_in <= 1'b1; ed; chopper_period_in <= 1'b0;
  endtask
  task fs; ed; fullstep_in <= 1'b1; ed; fullstep_in <= 1'b0; endtask
  task rup(input logic [7:0] v);
    ed; reg_value_in <= v; reg_update_in <= 1'b1;
    ed; reg_update_in <= 1'b0; sn;
  endtask
  task chk(input logic [19:0] got, input logic [19:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  task report_and_stop;
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task t_init;
    repeat (127) chp;
    sn; chk(voltage_mode_out, 1'b0);
    chp; sn; chk(voltage_mode_out, 1'b1);
    chk(init_done_out, 1'b1);
  endtask
  task t_thr;
    ed; standstill_in <= 1'b0; otp_load_in <= 1'b1;
    otp_threshold_in <= 20'h00064;
    ed; otp_load_in <= 1'b0;
    sn; chk(velocity_mode_threshold_out, 20'h00064);
    ed; threshold_write_in <= 1'b1; threshold_data_in <= 20'h00032;
    otp_load_in <= 1'b1; otp_threshold_in <= 20'h00099;
    ed; threshold_write_in <= 1'b0; otp_load_in <= 1'b0;
    sn; chk(velocity_mode_threshold_out, 20'h00032);
    ed; step_interval_measure_in <= 20'h00031;
    wt; chk(voltage_mode_out, 1'b0);
    ed; step_interval_measure_in <= 20'h00032;
    wt; chk(voltage_mode_out, 1'b1);
    // Threshold rewritten only once back in voltage mode
    ed; threshold_write_in <= 1'b1; threshold_data_in <= 20'h00000;
    ed; threshold_write_in <= 1'b0;
    ed; step_interval_measure_in <= 20'h00001;
    wt; wt; chk(voltage_mode_out, 1'b1);
  endtask
  task t_sel;
    for (int i = 0; i < 4; i++) begin
      ed; {voltage_mode_disable_in, chopper_select_pin_in} <= 2'(i);
      wt; chk(voltage_mode_out, 1'(i == 0 || i == 3));
    end
    // Both low again so later toggles of the bit really leave voltage mode
    ed; {voltage_mode_disable_in, chopper_select_pin_in} <= 2'h0;
  endtask
  task t_hold;
    rup(8'h5A); chk(reg_hold_out, 8'h5A);
    ed; voltage_mode_disable_in <= 1'b1;
    rup(8'h33); chk(voltage_mode_out, 1'b0);
    ed; voltage_mode_disable_in <= 1'b0;
    wt; chk(reg_hold_out, 8'h5A);
    ed; target_zero_in <= 1'b1;
    rup(8'h77); chk(reg_hold_out, 8'h5A);
    ed; target_zero_in <= 1'b0;
  endtask
  task t_open;
    ed; open_a <= 1'b1;
    repeat (3) fs;
    sn; chk(open_load_coil_a_out, 1'b0);
    fs; sn;
    chk({open_load_coil_a_out, open_load_coil_b_out}, 2'h2);
    repeat (2) fs;
    sn; chk(open_load_coil_a_out, 1'b1);
    // On-demand check done with current mode selected
    ed; voltage_mode_disable_in <= 1'b1;
    wt; wt; chk(open_load_coil_a_out, 1'b0);
    ed; voltage_mode_disable_in <= 1'b0;
    wt;
    repeat (4) fs;
    sn; chk(open_load_coil_a_out, 1'b1);
    ed; open_a <= 1'b0;
    fs; sn; chk(open_load_coil_a_out, 1'b0);
  endtask
  task t_amp;
    logic [8:0] dem [3] = '{9'h0C8, 9'h0FF, 9'h12C};
    ed; autoscale_in <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      ed; amp_demand_in <= dem[i];
      wt; chk(pwm_amplitude_total_out, (i == 0) ? 8'hC8 : 8'hFF);
      chk(amp_saturated_out, 1'(i != 0));
    end
  endtask
  task t_brake;
    logic [2:0] want [4] = '{3'h4, 3'h0, 3'h2, 3'h1};
    ed; standstill_current_in <= 5'h00; powerdown_done_in <= 1'b1;
    standstill_option_in <= OPT_STANDSTILL_OPTION;
    wt; chk(bridge_bits, 3'h4);
    ed; hold_ramp_done_in <= 1'b1;
    for (int o = 0; o < 4; o++) begin
      ed; standstill_option_in <= 2'(o);
      wt; chk(bridge_bits, want[o]);
    end
  endtask
  // Recovery: flags cleared, motion restarted from standstill
  task t_rst;
    ed; reset_in <= 1'b1; standstill_in <= 1'b1;
    repeat (2) ed;
    reset_in <= 1'b0;
    sn; chk({voltage_mode_out, init_done_out, open_load_coil_a_out}, 3'h0);
    chk(velocity_mode_threshold_out, 20'h00000);
    wt; chk(bridge_bits, 3'h4);
    t_init;
  endtask
  // Ceiling well above the few hundred cycles the run needs
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 5000) begin
      errors++;
      report_and_stop;
    end
  end
  initial begin
    clk_in = 1'b0;
    forever #2.5 clk_in = ~clk_in;
  end
  initial begin
    {otp_load_in, threshold_write_in, voltage_mode_disable_in, open_a,
     chopper_select_pin_in, autoscale_in, chopper_period_in, open_b,
     fullstep_in, powerdown_done_in, hold_ramp_done_in, target_zero_in,
     reg_update_in, otp_threshold_in, threshold_data_in, amp_demand_in,
     reg_value_in, standstill_option_in} = '0;
    {errors, comparisons, cycles} = '0;
    standstill_in = 1'b1;
    step_interval_measure_in = 20'hFFFFF;
    standstill_current_in = 5'h10;
    reset_in = 1'b1;
    repeat (5) ed;
    reset_in <= 1'b0;
    t_init; t_thr; t_sel; t_hold; t_open; t_amp; t_brake; t_rst;
    report_and_stop;
  end
endmodule
`default_nettype wire
